// ===== design/dsb_defines.svh
// offsets, bit positions, reset values and timing counts of the
// diagnostic status bank
// assumes a 100 MHz logic clock
`ifndef DSB_DEFINES_SVH
`define DSB_DEFINES_SVH

// register offsets on the serial register port
`define DSB_SR2_ADDR        8'h32
`define DSB_SR3_ADDR        8'h33

// register width and reset values
`define DSB_REG_W           24
`define DSB_SR2_RESET       24'h000000
`define DSB_SR3_RESET       24'h000000

// bit positions of the communication and supply register
`define DSB_B_LIN_BUS_DOM   23
`define DSB_B_LIN_TX_DOM    22
`define DSB_B_LIN_NOFOLLOW  21
`define DSB_B_CAN_RX_NOFOL  20
`define DSB_B_CAN_BUS_NOFOL 19
`define DSB_B_CAN_BUS_DOM   18
`define DSB_B_CAN_TX_DOM    17
`define DSB_B_CAN_SUPPLY_LOW_FLAG   16
`define DSB_B_BRA_HI        15
`define DSB_B_BRA_LO        12
`define DSB_B_INV_CMD       11
`define DSB_B_SCK_CNT       10
`define DSB_B_CHARGE_PUMP_LOW_FLAG        9
`define DSB_B_THERM         8
`define DSB_B_SEC_SHORT     7
`define DSB_B_SEC_FAIL      6
`define DSB_B_PRI_FAIL      5
`define DSB_B_REG_EW        4
`define DSB_B_REG_OV        3
`define DSB_B_REG_UV        2
`define DSB_B_BAT_OV        1
`define DSB_B_BAT_UV        0

// bit positions of the output overcurrent register
`define DSB_B_OC_BR_HI      23
`define DSB_B_OC_HS_HI      13
`define DSB_B_OC_HS_LO      10
`define DSB_B_OC_PCH        9
`define DSB_B_BRB_HI        6
`define DSB_B_BRB_LO        3
`define DSB_B_FS_B          1
`define DSB_B_FS_A          0

// channel counts
`define DSB_OC_CH           11
`define DSB_OC_BR_CH        10
`define DSB_CLUSTERS        6

// repeated mismatch limit for the CAN transmitter checks
`define DSB_CAN_FAIL_LIMIT  3'd4

// timing
`define DSB_CLK_PERIOD_NS   10
`define DSB_INT_PULSE_NS    1000
`define DSB_INT_PULSE_CYC   (`DSB_INT_PULSE_NS / `DSB_CLK_PERIOD_NS)

`endif

// ===== design/dsb_pkg.sv
// types shared by the diagnostic status bank files
// assumes dsb_defines.svh is on the include path
`include "dsb_defines.svh"

package dsb_pkg;

    // one register access from the serial frame decoder
    typedef struct packed {
        logic       valid;   // one-cycle strobe
        logic       write;   // frame is a write
        logic       clear;   // read-and-clear frame
        logic [7:0] addr;
    } dsb_acc_t;

    // serial frame checker events, one-cycle pulses
    typedef struct packed {
        logic undef_addr;
        logic di_stuck;
        logic cs_timeout;
        logic parity_fail;
        logic invalid_setting;
        logic frame_end;       // a frame finished
        logic sck_count_bad;   // with frame_end: wrong clock count
    } dsb_spi_evt_t;

    // causes for the communication and supply register
    typedef struct packed {
        logic                      lin_bus_stuck_dominant;
        logic                      lin_tx_input_stuck_dominant;
        logic                      lin_bus_not_following;
        logic                      can_rx_mismatch;   // pulse per bit
        logic                      can_rx_match;      // pulse per bit
        logic                      can_bus_mismatch;  // pulse per bit
        logic                      can_bus_match;     // pulse per bit
        logic                      can_bus_stuck_dominant;
        logic                      can_tx_input_stuck_dominant;
        logic                      can_supply_low;
        logic [3:0]                bridge_a_monitor;  // hs2 hs1 ls2 ls1
        logic                      charge_pump_low;
        logic [`DSB_CLUSTERS-1:0]  cluster_thermal_warning;
        logic                      secondary_regulator_short;
        logic                      secondary_regulator_fail;
        logic                      primary_regulator_fail;
        logic                      regulator_supply_early_warning;
        logic                      regulator_supply_overvoltage;
        logic                      regulator_supply_undervoltage;
        logic                      battery_overvoltage;
        logic                      battery_undervoltage;
    } dsb_sr2_cause_t;

    // simple causes for the output overcurrent register
    typedef struct packed {
        logic [3:0] highside_overcurrent;  // outputs of bits 13..10
        logic       failsafe_low_b_overcurrent;
        logic       failsafe_low_a_overcurrent;
        logic [3:0] bridge_b_monitor;      // hs2 hs1 ls2 ls1
    } dsb_sr3_cause_t;

    // one overcurrent-protected output with recovery
    typedef struct packed {
        logic overcurrent;
        logic overcurrent_recovery_enable;
        logic thermal_expiration_enable;
        logic thermal_expiration;
    } dsb_oc_ch_t;

endpackage : dsb_pkg

// ===== design/dsb_oc_channel.sv
// one overcurrent output channel with optional recovery mode
// assumes the clear strobe comes from an accepted read-and-clear
`timescale 1ns/10ps
`default_nettype none

module dsb_oc_channel
    import dsb_pkg::*;
(
    // clock and reset
    input  wire logic       i_ref_clk,
    input  wire logic       i_arst_n,
    // channel conditions
    input  wire dsb_oc_ch_t i_ch,
    input  wire logic       i_clear,
    // status and control
    output logic            o_shutdown,
    output logic            o_output_off,
    output logic            o_recovery_alert
);

    logic set_shutdown;
    logic in_recovery;

    // plain trip, or thermal expiration while recovering
    assign set_shutdown =
        (i_ch.overcurrent & ~i_ch.overcurrent_recovery_enable) |
        (in_recovery & i_ch.thermal_expiration_enable &
         i_ch.thermal_expiration);

    // recovery mode entered on overcurrent with recovery enabled;
    // an output already shut down does not re-enter it
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            in_recovery <= 1'b0;
        end else if (!i_ch.overcurrent_recovery_enable || set_shutdown) begin
            in_recovery <= 1'b0;
        end else if (i_ch.overcurrent && !o_shutdown) begin
            in_recovery <= 1'b1;
        end
    end

    // shutdown flag, set wins over clear
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_shutdown <= 1'b0;
        end else if (set_shutdown) begin
            o_shutdown <= 1'b1;
        end else if (i_clear) begin
            o_shutdown <= 1'b0;
        end
    end

    assign o_output_off     = o_shutdown;
    assign o_recovery_alert = in_recovery;

endmodule : dsb_oc_channel

`default_nettype wire

// ===== design/dsb_status_bank.sv
// diagnostic status bank: communication, supply and overcurrent flags
// assumes the serial frame decoder delivers one access strobe per
// frame and that all condition inputs are synchronous to the clock
`timescale 1ns/10ps
`default_nettype none

module dsb_status_bank
    import dsb_pkg::*;
(
    // clock and reset
    input  wire logic                           i_ref_clk,
    input  wire logic                           i_arst_n,
    // register access from the serial frame decoder
    input  wire dsb_acc_t                       i_acc,
    input  wire dsb_spi_evt_t                   i_spi_evt,
    input  wire logic                           i_generator_mode_en,
    output logic [`DSB_REG_W-1:0]               o_rd_data,
    output logic                                o_rd_valid,
    output logic                                o_acc_ignored,
    // fault causes
    input  wire dsb_sr2_cause_t                 i_sr2_cause,
    input  wire dsb_sr3_cause_t                 i_sr3_cause,
    input  wire dsb_oc_ch_t [`DSB_OC_CH-1:0]    i_oc_ch,
    input  wire logic                           i_active_mode,
    // transmitter and output control
    output logic                                o_lin_tx_disable,
    output logic                                o_can_tx_disable,
    output logic [`DSB_OC_CH-1:0]               o_output_off,
    output logic [`DSB_OC_CH-1:0]               o_recovery_alert_flag,
    // interrupt pin, active low
    output logic                                o_interrupt_output_pin_n
);

    //------------------------------------------------------------
    // access decode
    //------------------------------------------------------------

    logic                  hit_sr2;
    logic                  hit_sr3;
    logic                  acc_blocked;
    logic                  acc_bad;
    logic                  acc_read_ok;
    logic                  clr_sr2;
    logic                  clr_sr3;
    logic                  spi_err;

    // address match for the two registers
    always_comb begin
        hit_sr2 = 1'b0;
        hit_sr3 = 1'b0;
        if (i_acc.addr == `DSB_SR2_ADDR) begin
            hit_sr2 = 1'b1;
        end else if (i_acc.addr == `DSB_SR3_ADDR) begin
            hit_sr3 = 1'b1;
        end
    end

    // overvoltage with generator mode blocks every access
    assign acc_blocked = i_generator_mode_en &
                         i_sr2_cause.battery_overvoltage;
    // writes to a status register are refused
    assign acc_bad     = i_acc.valid & (hit_sr2 | hit_sr3) &
                         (i_acc.write | acc_blocked);
    assign acc_read_ok = i_acc.valid & (hit_sr2 | hit_sr3) &
                         ~i_acc.write & ~acc_blocked;
    assign clr_sr2     = acc_read_ok & i_acc.clear & hit_sr2;
    assign clr_sr3     = acc_read_ok & i_acc.clear & hit_sr3;

    // any checker frame error except the clock count, or refused here
    assign spi_err = i_spi_evt.undef_addr | i_spi_evt.di_stuck |
                     i_spi_evt.cs_timeout | i_spi_evt.parity_fail |
                     i_spi_evt.invalid_setting | acc_bad |
                     (i_acc.valid & acc_blocked);

    //------------------------------------------------------------
    // repeated CAN mismatch counters
    //------------------------------------------------------------

    logic [2:0] rx_fail_cnt;
    logic [2:0] bus_fail_cnt;
    logic       rx_fail_hit;
    logic       bus_fail_hit;

    assign rx_fail_hit  = i_sr2_cause.can_rx_mismatch &
                          (rx_fail_cnt == `DSB_CAN_FAIL_LIMIT - 3'd1);
    assign bus_fail_hit = i_sr2_cause.can_bus_mismatch &
                          (bus_fail_cnt == `DSB_CAN_FAIL_LIMIT - 3'd1);

    // count consecutive RX mismatches, a good bit restarts
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rx_fail_cnt <= 3'h0;
        end else if (i_sr2_cause.can_rx_match || rx_fail_hit) begin
            rx_fail_cnt <= 3'h0;
        end else if (i_sr2_cause.can_rx_mismatch) begin
            rx_fail_cnt <= rx_fail_cnt + 3'h1;
        end
    end

    // count consecutive bus mismatches, a good bit restarts
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            bus_fail_cnt <= 3'h0;
        end else if (i_sr2_cause.can_bus_match || bus_fail_hit) begin
            bus_fail_cnt <= 3'h0;
        end else if (i_sr2_cause.can_bus_mismatch) begin
            bus_fail_cnt <= bus_fail_cnt + 3'h1;
        end
    end

    //------------------------------------------------------------
    // communication and supply register
    //------------------------------------------------------------

    logic [`DSB_REG_W-1:0] sr2;
    logic [`DSB_REG_W-1:0] sr2_set;
    logic [`DSB_REG_W-1:0] next_sr2;

    // set vector: bits 8 and 11 OR several causes, bit 10 stays zero here, one cause per bit elsewhere; reserved none here
    always_comb begin
        sr2_set = `DSB_SR2_RESET;
        sr2_set[`DSB_B_LIN_BUS_DOM]   =
            i_sr2_cause.lin_bus_stuck_dominant;
        sr2_set[`DSB_B_LIN_TX_DOM]    =
            i_sr2_cause.lin_tx_input_stuck_dominant;
        sr2_set[`DSB_B_LIN_NOFOLLOW]  =
            i_sr2_cause.lin_bus_not_following;
        sr2_set[`DSB_B_CAN_RX_NOFOL]  = rx_fail_hit;
        sr2_set[`DSB_B_CAN_BUS_NOFOL] = bus_fail_hit;
        sr2_set[`DSB_B_CAN_BUS_DOM]   =
            i_sr2_cause.can_bus_stuck_dominant;
        sr2_set[`DSB_B_CAN_TX_DOM]    =
            i_sr2_cause.can_tx_input_stuck_dominant;
        sr2_set[`DSB_B_CAN_SUPPLY_LOW_FLAG]   = i_sr2_cause.can_supply_low;
        sr2_set[`DSB_B_BRA_HI:`DSB_B_BRA_LO] =
            i_sr2_cause.bridge_a_monitor;
        sr2_set[`DSB_B_INV_CMD]       = spi_err;
        sr2_set[`DSB_B_CHARGE_PUMP_LOW_FLAG]        = i_sr2_cause.charge_pump_low;
        sr2_set[`DSB_B_THERM]         =
            |i_sr2_cause.cluster_thermal_warning;
        sr2_set[`DSB_B_SEC_SHORT]     =
            i_sr2_cause.secondary_regulator_short;
        sr2_set[`DSB_B_SEC_FAIL]      =
            i_sr2_cause.secondary_regulator_fail;
        sr2_set[`DSB_B_PRI_FAIL]      =
            i_sr2_cause.primary_regulator_fail;
        sr2_set[`DSB_B_REG_EW]        =
            i_sr2_cause.regulator_supply_early_warning;
        sr2_set[`DSB_B_REG_OV]        =
            i_sr2_cause.regulator_supply_overvoltage;
        sr2_set[`DSB_B_REG_UV]        =
            i_sr2_cause.regulator_supply_undervoltage;
        sr2_set[`DSB_B_BAT_OV]        = i_sr2_cause.battery_overvoltage;
        sr2_set[`DSB_B_BAT_UV]        = i_sr2_cause.battery_undervoltage;
    end

    // clear then set, so a persisting cause survives a clear
    always_comb begin
        next_sr2 = sr2;
        if (clr_sr2) begin
            next_sr2 = `DSB_SR2_RESET;
            next_sr2[`DSB_B_SCK_CNT] = sr2[`DSB_B_SCK_CNT];
        end
        next_sr2 = next_sr2 | sr2_set;
        // clock count flag follows frames only
        if (i_spi_evt.frame_end) begin
            next_sr2[`DSB_B_SCK_CNT] = i_spi_evt.sck_count_bad;
        end
    end

    // latched flags of the communication and supply register
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            sr2 <= `DSB_SR2_RESET;
        end else begin
            sr2 <= next_sr2;
        end
    end

    // transmitters stay off while their blocking flags stand
    assign o_lin_tx_disable = sr2[`DSB_B_LIN_TX_DOM] |
                              sr2[`DSB_B_LIN_NOFOLLOW];
    assign o_can_tx_disable = sr2[`DSB_B_CAN_RX_NOFOL] |
                              sr2[`DSB_B_CAN_BUS_NOFOL] |
                              sr2[`DSB_B_CAN_TX_DOM];

    //------------------------------------------------------------
    // early warning interrupt pulse
    //------------------------------------------------------------

    localparam logic [7:0] INT_CYC = 8'(`DSB_INT_PULSE_CYC);
    logic [7:0] int_cnt;

    // a new early warning in active mode starts a low pulse;
    // one already running absorbs it, so a pulse never stretches
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            int_cnt <= 8'h00;
        end else if (sr2_set[`DSB_B_REG_EW] && !sr2[`DSB_B_REG_EW] &&
                     i_active_mode && (int_cnt == 8'h00)) begin
            int_cnt <= INT_CYC;
        end else if (int_cnt != 8'h00) begin
            int_cnt <= int_cnt - 8'h01;
        end
    end

    // drive the pin from a flop, low while counting
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_interrupt_output_pin_n <= 1'b1;
        end else begin
            o_interrupt_output_pin_n <= (int_cnt == 8'h00);
        end
    end

    //------------------------------------------------------------
    // output overcurrent register
    //------------------------------------------------------------

    logic [`DSB_OC_CH-1:0] oc_shutdown;
    logic [`DSB_REG_W-1:0] sr3_simple;
    logic [`DSB_REG_W-1:0] sr3_set;
    logic [`DSB_REG_W-1:0] sr3_view;

    // recovery-capable channels: ten bridge and lamp, one P-channel
    genvar ch;
    generate
        for (ch = 0; ch < `DSB_OC_CH; ch = ch + 1) begin : g_oc
            dsb_oc_channel u_ch (
                .i_ref_clk        (i_ref_clk),
                .i_arst_n         (i_arst_n),
                .i_ch             (i_oc_ch[ch]),
                .i_clear          (clr_sr3),
                .o_shutdown       (oc_shutdown[ch]),
                .o_output_off     (o_output_off[ch]),
                .o_recovery_alert (o_recovery_alert_flag[ch])
            );
        end
    endgenerate

    // set vector of the simple flags, reserved bits stay zero
    always_comb begin
        sr3_set = `DSB_SR3_RESET;
        sr3_set[`DSB_B_OC_HS_HI:`DSB_B_OC_HS_LO] =
            i_sr3_cause.highside_overcurrent;
        sr3_set[`DSB_B_FS_B] = i_sr3_cause.failsafe_low_b_overcurrent;
        sr3_set[`DSB_B_FS_A] = i_sr3_cause.failsafe_low_a_overcurrent;
        sr3_set[`DSB_B_BRB_HI:`DSB_B_BRB_LO] =
            i_sr3_cause.bridge_b_monitor;
    end

    // simple latched flags, set wins over clear
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            sr3_simple <= `DSB_SR3_RESET;
        end else if (clr_sr3) begin
            sr3_simple <= sr3_set;
        end else begin
            sr3_simple <= sr3_simple | sr3_set;
        end
    end

    // assemble the readable view; reserved positions read zero
    always_comb begin
        sr3_view = sr3_simple;
        sr3_view[`DSB_B_OC_BR_HI:`DSB_B_OC_BR_HI-`DSB_OC_BR_CH+1] =
            oc_shutdown[`DSB_OC_BR_CH-1:0];
        sr3_view[`DSB_B_OC_PCH] = oc_shutdown[`DSB_OC_CH-1];
    end

    //------------------------------------------------------------
    // read data and answer strobes
    //------------------------------------------------------------

    // capture value before any clear of the same access
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_rd_data <= `DSB_SR2_RESET;
        end else if (acc_read_ok && hit_sr2) begin
            o_rd_data <= sr2;
        end else if (acc_read_ok && hit_sr3) begin
            o_rd_data <= sr3_view;
        end
    end

    // one-cycle answer and refusal strobes
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_rd_valid    <= 1'b0;
            o_acc_ignored <= 1'b0;
        end else begin
            o_rd_valid    <= acc_read_ok;
            o_acc_ignored <= acc_bad;
        end
    end

endmodule : dsb_status_bank

`default_nettype wire

// ===== sim/dsb_status_bank_checker.sv
// port-level properties of the diagnostic status bank
// assumes one clock domain; bound to every bank instance
`timescale 1ns/10ps
`default_nettype none
module dsb_status_bank_checker
    import dsb_pkg::*;
(
    // clock, reset and inputs
    input wire logic              i_ref_clk,
    input wire logic              i_arst_n,
    input wire dsb_acc_t          i_acc,
    input wire dsb_spi_evt_t      i_spi_evt,
    input wire logic              i_generator_mode_en,
    input wire dsb_sr2_cause_t    i_sr2_cause,
    input wire dsb_sr3_cause_t    i_sr3_cause,
    input wire dsb_oc_ch_t [10:0] i_oc_ch,
    input wire logic              i_active_mode,
    // outputs watched
    input wire logic [23:0]       o_rd_data,
    input wire logic              o_rd_valid,
    input wire logic              o_acc_ignored,
    input wire logic              o_lin_tx_disable,
    input wire logic              o_can_tx_disable,
    input wire logic [10:0]       o_output_off,
    input wire logic [10:0]       o_recovery_alert_flag,
    input wire logic              o_interrupt_output_pin_n
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_arst_n);
    // access aimed at this bank, and the refusal condition
    wire logic hit = i_acc.valid && i_acc.addr[7:1] == 7'h19;
    wire logic blk = i_generator_mode_en & i_sr2_cause.battery_overvoltage;
    wire logic rd2 = hit && !i_acc.write && !blk && !i_acc.addr[0];

    rd_answer_a: assert property (hit && !i_acc.write && !blk
        |=> o_rd_valid && !o_acc_ignored) else $error("read unanswered");
    wr_refuse_a: assert property (hit && (i_acc.write || blk)
        |=> o_acc_ignored && !o_rd_valid) else $error("bad access taken");
    lin_off_a: assert property (i_sr2_cause.lin_bus_not_following
        || i_sr2_cause.lin_tx_input_stuck_dominant |=> o_lin_tx_disable)
        else $error("lin transmitter left on");
    can_off_a: assert property (i_sr2_cause.can_tx_input_stuck_dominant
        |=> o_can_tx_disable) else $error("can transmitter left on");
    therm_read_a: assert property ((|i_sr2_cause.cluster_thermal_warning)
        ##1 rd2 |=> o_rd_data[8]) else $error("thermal bit missing");
    rsvd_zero_a: assert property (o_rd_valid && $past(i_acc.addr) == 8'h33
        |-> o_rd_data[8:7] == 2'b00 && !o_rd_data[2])
        else $error("reserved bit set");
    oc_off_a: assert property (i_oc_ch[0].overcurrent
        && !i_oc_ch[0].overcurrent_recovery_enable
        |=> o_output_off[0] && !o_recovery_alert_flag[0])
        else $error("overcurrent output not off");
    oc_rec_a: assert property (i_oc_ch[0].overcurrent && !o_output_off[0]
        && i_oc_ch[0].overcurrent_recovery_enable
        && !i_oc_ch[0].thermal_expiration
        |=> !o_output_off[0] && o_recovery_alert_flag[0])
        else $error("recovery mode wrong");
    pch_off_a: assert property (i_oc_ch[10].overcurrent
        && !i_oc_ch[10].overcurrent_recovery_enable |=> o_output_off[10])
        else $error("p-channel output not off");
    int_len_a: assert property ($fell(o_interrupt_output_pin_n)
        |-> ##99 !o_interrupt_output_pin_n ##1 o_interrupt_output_pin_n)
        else $error("interrupt pulse length wrong");
endmodule : dsb_status_bank_checker
bind dsb_status_bank dsb_status_bank_checker i_chk (.i_ref_clk, .i_arst_n,
    .i_acc, .i_spi_evt, .i_generator_mode_en, .i_sr2_cause, .i_sr3_cause,
    .i_oc_ch, .i_active_mode, .o_rd_data, .o_rd_valid, .o_acc_ignored,
    .o_lin_tx_disable, .o_can_tx_disable, .o_output_off,
    .o_recovery_alert_flag, .o_interrupt_output_pin_n);
`default_nettype wire

// ===== sim/dsb_host_model.sv
// host side: turns a bench request into one access strobe
// assumes requests are single cycles spaced by the bench
`timescale 1ns/10ps
`default_nettype none
module dsb_host_model
    import dsb_pkg::*;
(
    // clock and request
    input  wire logic       i_ref_clk,
    input  wire logic       i_req,
    input  wire logic       i_write,
    input  wire logic       i_clear,
    input  wire logic [7:0] i_addr,
    // strobe towards the bank
    output var  dsb_acc_t   o_acc
);
    initial o_acc = '0;
    // idle address toggles so a stale value never looks valid
    always @(posedge i_ref_clk) begin
        o_acc <= {i_req, i_write & i_req, i_clear & i_req,
                  i_req ? i_addr : ~o_acc.addr};
    end
endmodule : dsb_host_model
`default_nettype wire

// ===== sim/diag_status_bank_two_three_tb_top.sv
// self-checking bench of the diagnostic status bank
// assumes the bound checker and the host model beside it
`timescale 1ns/10ps
`default_nettype none
module diag_status_bank_two_three_tb_top
    import dsb_pkg::*;
;
    logic clk = 0, rst_n = 0, gen = 0, act = 1, req = 0, wr = 0, cl = 0;
    logic [7:0] addr = 0;
    logic [23:0] rd_q;
    logic rv, ign, lin_d, can_d, int_n;
    logic [10:0] off, alrt;
    logic [28:0] r;
    dsb_acc_t acc;
    dsb_spi_evt_t evt = '0;
    dsb_sr2_cause_t c2 = '0;
    dsb_sr3_cause_t c3 = '0;
    dsb_oc_ch_t [10:0] oc = '0;
    int failures = 0, checks = 0, seed = 72, got, e;
    always #5 clk = ~clk;
    dsb_host_model i_host (.i_ref_clk(clk), .i_req(req), .i_write(wr),
        .i_clear(cl), .i_addr(addr), .o_acc(acc));
    dsb_status_bank i_dut (.i_ref_clk(clk), .i_arst_n(rst_n), .i_acc(acc),
        .i_spi_evt(evt), .i_generator_mode_en(gen), .o_rd_data(rd_q),
        .o_rd_valid(rv), .o_acc_ignored(ign), .i_sr2_cause(c2),
        .i_sr3_cause(c3), .i_oc_ch(oc), .i_active_mode(act),
        .o_lin_tx_disable(lin_d), .o_can_tx_disable(can_d),
        .o_output_off(off), .o_recovery_alert_flag(alrt),
        .o_interrupt_output_pin_n(int_n));
    task automatic complete_run();
        if (failures == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : complete_run
    task automatic chk(logic [23:0] seen, logic [23:0] want);
        checks++;
        if (seen !== want) begin
            failures++;
            $display("CHECK FAILED %0t: got %h want %h", $time, seen, want);
        end
    endtask : chk
    // one access; 1 = read answered, 2 = refused, 0 = silence
    task automatic access(logic [7:0] a, logic w, output int ans);
        @(posedge clk);
        {req, addr, wr, cl} <= {1'b1, a, w, 1'b1};
        @(posedge clk);
        req <= 0;
        ans = 0;
        for (int i = 0; i < 4 && ans == 0; i++) begin
            @(negedge clk);
            ans = rv === 1'b1 ? 1 : ign === 1'b1 ? 2 : 0;
        end
    endtask : access
    task automatic rdc(logic [7:0] a, int want);
        access(a, 1'b0, got);
        chk(got[23:0], 1);
        if (got != 1) complete_run();
        chk(rd_q, want[23:0]);
    endtask : rdc
    task automatic p2(logic [28:0] v, dsb_spi_evt_t s);
        @(posedge clk);
        {c2, evt} <= {v, s};
        @(posedge clk);
        {c2, evt} <= '0;
    endtask : p2
    // reference placement of level causes in the first register
    function automatic int map2(logic [28:0] v);
        map2 = v[7:0] | (|v[13:8]) << 8 | v[14] << 9 | v[18:15] << 12
            | v[21:19] << 16 | v[28:26] << 21;
    endfunction : map2
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1;
        rdc(8'h32, 0);
        rdc(8'h33, 0);
        for (int k = 0; k < 16; k++) begin
            r = $random(seed) & 29'h1c3fffff;
            act <= r[5];
            p2(r, '0);
            @(negedge clk);
            chk(lin_d, |r[27:26]);
            @(negedge clk);
            chk(int_n, !(r[4] && r[5]));
            rdc(8'h32, map2(r));
            rdc(8'h32, 0);
            repeat (100) @(posedge clk);
        end
        for (int j = 0; j < 2; j++) begin
            for (int n = 0; n < 7; n++) p2(1 << (25 - 2 * j - (n == 3)), '0);
            rdc(8'h32, 0);
            p2(1 << (25 - 2 * j), '0);
            @(negedge clk);
            chk(can_d, 1);
            rdc(8'h32, 1 << (20 - j));
        end
        for (int i = 2; i < 7; i++) begin
            p2('0, 1 << i);
            rdc(8'h32, 'h800);
        end
        access(8'h32, 1'b1, got);
        chk(got[23:0], 2);
        gen <= 1;
        c2 <= 29'h102;
        access(8'h33, 1'b0, got);
        chk(got[23:0], 2);
        gen <= 0;
        rdc(8'h32, 'h902);
        rdc(8'h32, 'h102);
        c2 <= '0;
        rdc(8'h32, 'h102);
        access(8'h40, 1'b0, got);
        chk(got[23:0], 0);
        p2('0, 7'h03);
        rdc(8'h32, 'h400);
        rdc(8'h32, 'h400);
        p2('0, 7'h02);
        rdc(8'h32, 0);
        for (int k = 0; k < 8; k++) begin
            r = $random(seed);
            @(posedge clk);
            c3 <= r[9:0];
            for (int i = 0; i < 11; i++) oc[i] <= {1'b1, r[10 + i], 2'b00};
            @(posedge clk);
            c3 <= '0;
            @(negedge clk);
            chk(alrt, r[20:10]);
            chk(off, ~r[20:10] & 11'h7ff);
            for (int i = 0; i < 11; i++) oc[i] <= {1'b1, r[10 + i], 2'b11};
            @(negedge clk);
            chk(off, 11'h7ff);
            chk(alrt, 0);
            oc <= '0;
            e = r[9:6] << 10 | r[5] << 1 | r[4] | r[3:0] << 3 | 'hffc200;
            rdc(8'h33, e);
            rdc(8'h33, 0);
        end
        complete_run();
    end
endmodule : diag_status_bank_two_three_tb_top
`default_nettype wire
